// ===== design/rf_frame_integrity_guard.sv
// RF frame integrity: parity, CRC append/check/strip, receive guard time
`timescale 1ns/1ns
module rf_frame_integrity_guard (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Bit clock and transmit end
  input wire logic bitClkTick,
  input wire logic txEnd,
  // Transmit byte stream in
  input wire logic txStart,
  input wire logic txDataValid,
  input wire logic [7:0] txData,
  input wire logic txDataLast,
  output logic txReady,
  // Transmit byte stream out
  output logic txOutValid,
  output rfg_pkg::rfg_tx_byte_t txOut,
  // Receive bits in
  input wire logic rxFrameStart,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxFrameEnd,
  // Receive bytes out
  output logic rxOutValid,
  output rfg_pkg::rfg_rx_byte_t rxOut,
  output logic rxFrameDone,
  output logic rxCrcOk,
  output logic rxGuardActive
);

////////////////////////////////////////////////////////////////////////////////
// Registers

  logic [7:0] receive_guard_cycles;
  logic [7:0] ctrl;
  logic [7:0] crc_start_low_byte;
  logic [7:0] crc_start_high_byte;
  logic [7:0] fixedReg;
  logic crc_error_flag;
  logic parityErrFlag;
  logic crcErrSet;
  logic parErrSet;
  logic [15:0] crcResult;
  logic crc_compute_command;

  logic shortSel;
  logic altSel;
  logic parityOn;
  logic parity_polarity_odd;
  logic [15:0] presetValue;
  assign parityOn = ctrl[rfg_pkg::CTRL_PARITY_EN];
  assign parity_polarity_odd = ctrl[rfg_pkg::CTRL_PARITY_ODD];
  assign shortSel = ctrl[rfg_pkg::CTRL_SHORT];
  assign altSel = ctrl[rfg_pkg::CTRL_ALT];
  // High preset byte dropped in short mode
  assign presetValue = shortSel ? {8'h00, crc_start_low_byte}
                                : {crc_start_high_byte, crc_start_low_byte};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receive_guard_cycles <= rfg_pkg::RST_GUARD;
      ctrl <= rfg_pkg::RST_CTRL;
      crc_start_low_byte <= rfg_pkg::RST_PRESET;
      crc_start_high_byte <= rfg_pkg::RST_PRESET;
      fixedReg <= rfg_pkg::RST_FIXED;
    end else if (regWrite) begin
      case (regAddr)
        rfg_pkg::ADDR_GUARD: receive_guard_cycles <= regWdata;
        rfg_pkg::ADDR_CTRL: ctrl <= regWdata;
        rfg_pkg::ADDR_PRESET_LO: crc_start_low_byte <= regWdata;
        rfg_pkg::ADDR_PRESET_HI: crc_start_high_byte <= regWdata;
        rfg_pkg::ADDR_FIXED: fixedReg <= regWdata;
        default: ;
      endcase
    end
  end

  assign crc_compute_command = regWrite && (regAddr == rfg_pkg::ADDR_COMMAND)
                               && regWdata[rfg_pkg::CMD_CRC_COMPUTE];

  // Sticky flags, write one to clear; a new event wins over the clear
  logic statusWrite;
  assign statusWrite = regWrite && (regAddr == rfg_pkg::ADDR_STATUS);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_error_flag <= 1'b0;
      parityErrFlag <= 1'b0;
    end else begin
      if (crcErrSet) begin
        crc_error_flag <= 1'b1;
      end else if (statusWrite && regWdata[rfg_pkg::STAT_CRC_ERR]) begin
        crc_error_flag <= 1'b0;
      end
      if (parErrSet) begin
        parityErrFlag <= 1'b1;
      end else if (statusWrite && regWdata[rfg_pkg::STAT_PAR_ERR]) begin
        parityErrFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        rfg_pkg::ADDR_GUARD: regRdata <= receive_guard_cycles;
        rfg_pkg::ADDR_CTRL: regRdata <= ctrl;
        rfg_pkg::ADDR_PRESET_LO: regRdata <= crc_start_low_byte;
        rfg_pkg::ADDR_PRESET_HI: regRdata <= crc_start_high_byte;
        rfg_pkg::ADDR_FIXED: regRdata <= fixedReg;
        rfg_pkg::ADDR_STATUS: regRdata <= {5'h00, rxGuardActive,
                                           parityErrFlag, crc_error_flag};
        rfg_pkg::ADDR_RESULT_LO: regRdata <= crcResult[7:0];
        rfg_pkg::ADDR_RESULT_HI: regRdata <= crcResult[15:8];
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Receive guard time

  logic [7:0] guardCount;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      guardCount <= 8'h00;
      rxGuardActive <= 1'b0;
    end else if (txEnd) begin
      guardCount <= receive_guard_cycles;
      rxGuardActive <= (receive_guard_cycles != 8'h00);
    end else if (rxGuardActive && bitClkTick) begin
      guardCount <= guardCount - 8'h01;
      rxGuardActive <= (guardCount != 8'h01);
    end
  end

  logic rxStartOk;
  logic rxBitOk;
  logic rxEndOk;
  // Nothing from the receiver reaches the decoder while guarding
  assign rxStartOk = rxFrameStart && !rxGuardActive;
  assign rxBitOk = rxBitValid && !rxGuardActive;
  assign rxEndOk = rxFrameEnd && !rxGuardActive;

////////////////////////////////////////////////////////////////////////////////
// Transmit path

  rfg_pkg::rfg_tx_state_t txState;
  rfg_pkg::rfg_tx_state_t next_txState;
  logic [15:0] txCrc;
  logic [15:0] txCrcOut;
  logic txTake;
  assign txTake = txDataValid && txReady;
  assign txCrcOut = rfg_pkg::crcFinal(txCrc, shortSel, altSel);

  always_comb begin
    next_txState = txState;
    case (txState)
      rfg_pkg::TX_IDLE: begin
        if (crc_compute_command) begin
          next_txState = rfg_pkg::TX_CALC;
        end else if (txStart) begin
          next_txState = rfg_pkg::TX_DATA;
        end
      end
      rfg_pkg::TX_DATA: begin
        if (txTake && txDataLast) begin
          next_txState = ctrl[rfg_pkg::CTRL_TX_CRC] ? rfg_pkg::TX_CRC_LO
                                                    : rfg_pkg::TX_IDLE;
        end
      end
      rfg_pkg::TX_CRC_LO: begin
        next_txState = shortSel ? rfg_pkg::TX_IDLE : rfg_pkg::TX_CRC_HI;
      end
      rfg_pkg::TX_CRC_HI: next_txState = rfg_pkg::TX_IDLE;
      rfg_pkg::TX_CALC: begin
        if (txTake && txDataLast) begin
          next_txState = rfg_pkg::TX_IDLE;
        end
      end
      default: next_txState = rfg_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txState <= rfg_pkg::TX_IDLE;
      txReady <= 1'b0;
    end else begin
      txState <= next_txState;
      txReady <= (next_txState == rfg_pkg::TX_DATA) || (next_txState == rfg_pkg::TX_CALC);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txCrc <= 16'h0000;
      crcResult <= 16'h0000;
    end else if (txState == rfg_pkg::TX_IDLE && (txStart || crc_compute_command)) begin
      txCrc <= presetValue;
    end else if (txTake) begin
      txCrc <= rfg_pkg::crcStep(txCrc, txData, shortSel);
      if (txDataLast) begin
        crcResult <= rfg_pkg::crcFinal(rfg_pkg::crcStep(txCrc, txData, shortSel),
                                       shortSel, altSel);
      end
    end
  end

  logic [7:0] txByteNow;
  logic txSendNow;
  logic txLastNow;
  always_comb begin
    txByteNow = txData;
    txSendNow = 1'b0;
    txLastNow = 1'b0;
    case (txState)
      rfg_pkg::TX_DATA: begin
        txSendNow = txTake;
        txLastNow = txDataLast && !ctrl[rfg_pkg::CTRL_TX_CRC];
      end
      rfg_pkg::TX_CRC_LO: begin
        txByteNow = txCrcOut[7:0];
        txSendNow = 1'b1;
        txLastNow = shortSel;
      end
      rfg_pkg::TX_CRC_HI: begin
        txByteNow = txCrcOut[15:8];
        txSendNow = 1'b1;
        txLastNow = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txOutValid <= 1'b0;
      txOut <= '0;
    end else begin
      txOutValid <= txSendNow;
      txOut.data <= txByteNow;
      txOut.parity <= (^txByteNow) ^ parity_polarity_odd;
      txOut.parity_bit_en <= parityOn;
      txOut.last <= txLastNow;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Receive byte assembly and parity check

  logic [7:0] rxShift;
  logic [3:0] rxBitCount;
  logic asmValid;
  logic [7:0] asmByte;
  logic asmParErr;
  logic endSeen;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxShift <= 8'h00;
      rxBitCount <= 4'h0;
      asmValid <= 1'b0;
      asmByte <= 8'h00;
      asmParErr <= 1'b0;
      endSeen <= 1'b0;
    end else begin
      asmValid <= 1'b0;
      asmParErr <= 1'b0;
      endSeen <= rxEndOk;
      if (rxStartOk) begin
        rxBitCount <= 4'h0;
      end else if (rxBitOk) begin
        if (rxBitCount == rfg_pkg::PARITY_BIT_IDX) begin
          // Ninth bit only appears with parity on
          asmValid <= 1'b1;
          asmByte <= rxShift;
          asmParErr <= rxBit != ((^rxShift) ^ parity_polarity_odd);
          rxBitCount <= 4'h0;
        end else if (rxBitCount == 4'h7 && !parityOn) begin
          asmValid <= 1'b1;
          asmByte <= {rxBit, rxShift[7:1]};
          rxBitCount <= 4'h0;
        end else begin
          rxShift <= {rxBit, rxShift[7:1]};
          rxBitCount <= rxBitCount + 4'h1;
        end
      end
    end
  end

  assign parErrSet = asmParErr;

////////////////////////////////////////////////////////////////////////////////
// Receive CRC hold-back, check and strip

  logic [7:0] hold0;
  logic [7:0] hold1;
  logic [1:0] holdCount;
  logic [1:0] holdNeed;
  logic [15:0] rxCrc;
  logic [15:0] rxCrcFinal;
  logic draining;
  logic drainIdx;
  logic crcMatch;

  assign holdNeed = !ctrl[rfg_pkg::CTRL_RX_CRC] ? 2'd0 : (shortSel ? 2'd1 : 2'd2);
  assign rxCrcFinal = rfg_pkg::crcFinal(rxCrc, shortSel, altSel);
  assign crcMatch = (holdCount == holdNeed) && (hold0 == rxCrcFinal[7:0])
                    && (shortSel || hold1 == rxCrcFinal[15:8]);
  assign crcErrSet = endSeen && (holdNeed != 2'd0) && !crcMatch;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold0 <= 8'h00;
      hold1 <= 8'h00;
      holdCount <= 2'd0;
      rxCrc <= 16'h0000;
      draining <= 1'b0;
      drainIdx <= 1'b0;
      rxOutValid <= 1'b0;
      rxOut <= '0;
      rxFrameDone <= 1'b0;
      rxCrcOk <= 1'b0;
    end else begin
      rxOutValid <= 1'b0;
      rxFrameDone <= 1'b0;
      if (rxStartOk) begin
        rxCrc <= presetValue;
        holdCount <= 2'd0;
        draining <= 1'b0;
      end else if (draining) begin
        // Failed check: held bytes are data after all
        rxOutValid <= 1'b1;
        rxOut.data <= drainIdx ? hold1 : hold0;
        rxOut.parityErr <= 1'b0;
        drainIdx <= 1'b1;
        if (drainIdx || holdCount == 2'd1) begin
          draining <= 1'b0;
          holdCount <= 2'd0;
          rxFrameDone <= 1'b1;
        end
      end else if (endSeen) begin
        rxCrcOk <= crcMatch;
        if (holdNeed != 2'd0 && !crcMatch && holdCount != 2'd0) begin
          draining <= 1'b1;
          drainIdx <= 1'b0;
        end else begin
          holdCount <= 2'd0;
          rxFrameDone <= 1'b1;
        end
      end else if (asmValid) begin
        if (holdNeed == 2'd0) begin
          rxOutValid <= 1'b1;
          rxOut.data <= asmByte;
          rxOut.parityErr <= asmParErr;
        end else if (holdCount < holdNeed) begin
          if (holdCount == 2'd0) begin
            hold0 <= asmByte;
          end else begin
            hold1 <= asmByte;
          end
          holdCount <= holdCount + 2'd1;
        end else begin
          // Oldest held byte is data; newest joins the trailer
          rxOutValid <= 1'b1;
          rxOut.data <= hold0;
          rxOut.parityErr <= asmParErr;
          rxCrc <= rfg_pkg::crcStep(rxCrc, hold0, shortSel);
          if (holdNeed == 2'd2) begin
            hold0 <= hold1;
            hold1 <= asmByte;
          end else begin
            hold0 <= asmByte;
          end
        end
      end
    end
  end

endmodule // rf_frame_integrity_guard

// ===== design/rfg_pkg.sv
// Package: register map, field positions, reset values, CRC helpers
package rfg_pkg;
  localparam logic [7:0] ADDR_GUARD = 8'h21;
  localparam logic [7:0] ADDR_CTRL = 8'h22;
  localparam logic [7:0] ADDR_PRESET_LO = 8'h23;
  localparam logic [7:0] ADDR_PRESET_HI = 8'h24;
  localparam logic [7:0] ADDR_FIXED = 8'h25;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_COMMAND = 8'h31;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h32;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h33;

  localparam int CTRL_PARITY_EN = 0;
  localparam int CTRL_PARITY_ODD = 1;
  localparam int CTRL_TX_CRC = 2;
  localparam int CTRL_RX_CRC = 3;
  localparam int CTRL_SHORT = 4;
  localparam int CTRL_ALT = 5;
  localparam int STAT_CRC_ERR = 0;
  localparam int STAT_PAR_ERR = 1;
  localparam int STAT_GUARD = 2;
  localparam int CMD_CRC_COMPUTE = 0;

  localparam logic [7:0] RST_GUARD = 8'h06;
  localparam logic [7:0] RST_CTRL = 8'h03;
  localparam logic [7:0] RST_PRESET = 8'h63;
  localparam logic [7:0] RST_FIXED = 8'h00;

  localparam logic [15:0] CRC16_POLY = 16'h8408;
  localparam logic [7:0] CRC_SHORT_WIDTH_SEL_POLY = 8'hb8;
  localparam logic [15:0] CRC16_XOR = 16'hffff;
  localparam logic [15:0] CRC_SHORT_WIDTH_SEL_XOR = 16'h00ff;
  localparam logic [3:0] PARITY_BIT_IDX = 4'h8;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DATA = 3'b001,
    TX_CRC_LO = 3'b010,
    TX_CRC_HI = 3'b011,
    TX_CALC = 3'b100
  } rfg_tx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity;
    logic parity_bit_en;
    logic last;
  } rfg_tx_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic parityErr;
  } rfg_rx_byte_t;

  // One byte through a reflected (LSB-first) CRC register
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d,
                                          input logic short8);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      if (short8) begin
        r = {8'h00, (r[7:0] >> 1) ^ (r[0] ? CRC_SHORT_WIDTH_SEL_POLY : 8'h00)};
      end else begin
        r = (r >> 1) ^ (r[0] ? CRC16_POLY : 16'h0000);
      end
    end
    return r;
  endfunction

  // Alternate algorithm complements the result
  function automatic logic [15:0] crcFinal(input logic [15:0] c, input logic short8,
                                           input logic alt);
    logic [15:0] x;
    x = alt ? (short8 ? CRC_SHORT_WIDTH_SEL_XOR : CRC16_XOR) : 16'h0000;
    return c ^ x;
  endfunction
endpackage

// ===== verif/rf_frame_integrity_guard_tb.sv
// Testbench: registers, transmit framing, CRC compute, receive check, guard time
`timescale 1ns/1ns
module rf_frame_integrity_guard_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic bitClkTick = 1'b0;
  logic txEnd = 1'b0;
  logic txStart = 1'b0;
  logic txDataValid = 1'b0;
  logic [7:0] txData = 8'h00;
  logic txDataLast = 1'b0;
  logic [7:0] regRdata;
  logic txReady, txOutValid, rxFrameStart, rxBitValid, rxBit, rxFrameEnd;
  logic rxOutValid, rxFrameDone, rxCrcOk, rxGuardActive;
  rfg_pkg::rfg_tx_byte_t txOut;
  rfg_pkg::rfg_rx_byte_t rxOut;
  logic [7:0] rxQ[$];
  logic [7:0] fr[$];
  logic [7:0] ex[$];
  logic [7:0] v;
  logic [15:0] c;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int perr = 0;
  int rxDone = 0;
  // Upper two control bits kept zero; 07h is odd parity for 14443 A
  logic [7:0] modes [4] = '{8'h07, 8'h25, 8'h14, 8'h01};
  logic [7:0] rAddr [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h40};
  logic [7:0] rExp [6] = '{8'h06, 8'h03, 8'h63, 8'h63, 8'h00, 8'h00};
  always #25 clk = ~clk;
  rf_frame_integrity_guard dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .bitClkTick(bitClkTick),
    .txEnd(txEnd), .txStart(txStart), .txDataValid(txDataValid), .txData(txData),
    .txDataLast(txDataLast), .txReady(txReady), .txOutValid(txOutValid), .txOut(txOut),
    .rxFrameStart(rxFrameStart), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .rxFrameEnd(rxFrameEnd), .rxOutValid(rxOutValid), .rxOut(rxOut),
    .rxFrameDone(rxFrameDone), .rxCrcOk(rxCrcOk), .rxGuardActive(rxGuardActive)
  );
  rfg_card_model card (
    .clk(clk), .txOutValid(txOutValid), .txOut(txOut), .rxFrameStart(rxFrameStart),
    .rxBitValid(rxBitValid), .rxBit(rxBit), .rxFrameEnd(rxFrameEnd)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Bit clock every eighth cycle, receive monitor, hang limit
  always @(posedge clk) begin
    cyc++;
    bitClkTick <= (cyc % 8 == 7);
    if (rxOutValid === 1'b1) rxQ.push_back(rxOut.data);
    if (rxOutValid === 1'b1 && rxOut.parityErr === 1'b1) perr++;
    if (rxFrameDone === 1'b1) rxDone++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    // Read data stand only in the cycle after the strobe
    #1;
    d = regRdata;
    @(posedge clk);
  endtask
  task automatic tx_bytes(input logic start);
    if (start) begin
      txStart <= 1'b1;
      @(posedge clk);
      txStart <= 1'b0;
    end
    foreach (fr[i]) begin
      txDataValid <= 1'b1;
      txData <= fr[i];
      txDataLast <= (i == fr.size() - 1);
      @(posedge clk);
      while (txReady !== 1'b1) @(posedge clk);
    end
    txDataValid <= 1'b0;
    txDataLast <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [15:0] crc_of(input logic [7:0] d[$], input logic [7:0] lo,
                                         input logic [7:0] hi, input logic s8, input logic alt);
    logic [15:0] r;
    r = s8 ? {8'h00, lo} : {hi, lo};
    foreach (d[i]) begin
      r = r ^ {8'h00, d[i]};
      for (int k = 0; k < 8; k++) begin
        if (s8) r = {8'h00, {1'b0, r[7:1]} ^ (r[0] ? rfg_pkg::CRC_SHORT_WIDTH_SEL_POLY : 8'h00)};
        else r = {1'b0, r[15:1]} ^ (r[0] ? rfg_pkg::CRC16_POLY : 16'h0000);
      end
    end
    if (alt) r = r ^ (s8 ? rfg_pkg::CRC_SHORT_WIDTH_SEL_XOR : rfg_pkg::CRC16_XOR);
    return r;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rAddr[i]) begin
      rd(rAddr[i], v);
      check(v, rExp[i]);
    end
    $display("register reset test done");
    wr(rfg_pkg::ADDR_PRESET_LO, 8'h6b);
    wr(rfg_pkg::ADDR_PRESET_HI, 8'h1e);
    fr = '{8'ha5, 8'h3c};
    foreach (modes[m]) begin
      wr(rfg_pkg::ADDR_CTRL, modes[m]);
      card.heard.delete();
      tx_bytes(1'b1);
      c = crc_of(fr, 8'h6b, 8'h1e, modes[m][4], modes[m][5]);
      ex = fr;
      if (modes[m][2]) ex.push_back(c[7:0]);
      if (modes[m][2] && !modes[m][4]) ex.push_back(c[15:8]);
      check(16'(card.heard.size()), 16'(ex.size()));
      foreach (card.heard[i]) begin
        check(card.heard[i].data, ex[i]);
        check(card.heard[i].parity_bit_en, modes[m][0]);
        if (modes[m][0]) check(card.heard[i].parity, ^ex[i] ^ modes[m][1]);
      end
      $display("transmit mode %h test done", modes[m]);
    end
    wr(rfg_pkg::ADDR_CTRL, 8'h07);
    card.heard.delete();
    wr(rfg_pkg::ADDR_COMMAND, 8'h01);
    tx_bytes(1'b0);
    c = crc_of(fr, 8'h6b, 8'h1e, 1'b0, 1'b0);
    rd(rfg_pkg::ADDR_RESULT_LO, v);
    check(v, c[7:0]);
    rd(rfg_pkg::ADDR_RESULT_HI, v);
    check(v, c[15:8]);
    check(16'(card.heard.size()), 16'h0000);
    $display("compute command test done");
    wr(rfg_pkg::ADDR_CTRL, 8'h0b);
    fr = '{8'ha5, 8'h3c, c[7:0], c[15:8]};
    for (int bad = 0; bad < 2; bad++) begin
      rxQ.delete();
      if (bad == 1) fr[3] = ~fr[3];
      card.send(fr, 1'b1, 1'b1);
      repeat (8) @(posedge clk);
      check(16'(rxQ.size()), (bad == 1) ? 16'h0004 : 16'h0002);
      check(rxQ[1], 8'h3c);
      check(rxCrcOk, bad == 0);
      rd(rfg_pkg::ADDR_STATUS, v);
      check(v[0], bad == 1);
    end
    $display("receive check test done");
    wr(rfg_pkg::ADDR_CTRL, 8'h03);
    wr(rfg_pkg::ADDR_GUARD, 8'h05);
    fr = '{8'h5a};
    rxQ.delete();
    perr = 0;
    rxDone = 0;
    txEnd <= 1'b1;
    @(posedge clk);
    txEnd <= 1'b0;
    rd(rfg_pkg::ADDR_STATUS, v);
    check(v[2], 1'b1);
    card.send(fr, 1'b1, 1'b1);
    check(16'(rxQ.size() + rxDone), 16'h0000);
    repeat (48) @(posedge clk);
    check(rxGuardActive, 1'b0);
    card.send(fr, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    check(16'(rxQ.size()), 16'h0001);
    check(16'(perr), 16'h0001);
    check(16'(rxDone), 16'h0001);
    rd(rfg_pkg::ADDR_STATUS, v);
    check(v[1], 1'b1);
    wr(rfg_pkg::ADDR_GUARD, 8'h00);
    txEnd <= 1'b1;
    @(posedge clk);
    txEnd <= 1'b0;
    repeat (2) @(posedge clk);
    check(rxGuardActive, 1'b0);
    $display("guard time test done");
    tally_and_finish();
  end
endmodule // rf_frame_integrity_guard_tb

// ===== verif/rfg_card_model.sv
// Card model: records reader bytes, answers with framed bit streams
`timescale 1ns/1ns
module rfg_card_model (
  // Clock
  input wire logic clk,
  // Reader to card
  input wire logic txOutValid,
  input wire rfg_pkg::rfg_tx_byte_t txOut,
  // Card to reader
  output logic rxFrameStart,
  output logic rxBitValid,
  output logic rxBit,
  output logic rxFrameEnd
);
  rfg_pkg::rfg_tx_byte_t heard[$];
  initial begin
    rxFrameStart = 1'b0;
    rxBitValid = 1'b0;
    rxBit = 1'b0;
    rxFrameEnd = 1'b0;
  end
  always @(posedge clk) begin
    if (txOutValid === 1'b1) heard.push_back(txOut);
  end
  // One bit every two cycles, line inverted between bits
  task automatic send(input logic [7:0] b[$], input logic par, input logic odd);
    logic v;
    rxFrameStart <= 1'b1;
    @(posedge clk);
    rxFrameStart <= 1'b0;
    foreach (b[i]) begin
      for (int k = 0; k < 9; k++) begin
        if (k < 8 || par) begin
          v = (k < 8) ? b[i][k] : (^b[i] ^ odd);
          rxBitValid <= 1'b1;
          rxBit <= v;
          @(posedge clk);
          rxBitValid <= 1'b0;
          rxBit <= ~v;
          @(posedge clk);
        end
      end
    end
    rxFrameEnd <= 1'b1;
    @(posedge clk);
    rxFrameEnd <= 1'b0;
  endtask
endmodule // rfg_card_model

// ===== verif/rfg_chk.sv
// Checker: guard timing and transmit stream relations at the block's ports
`timescale 1ns/1ns
module rfg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register writes
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  // Guard and receive
  input wire logic bitClkTick,
  input wire logic txEnd,
  input wire logic rxGuardActive,
  input wire logic rxOutValid,
  input wire logic rxFrameDone,
  // Transmit
  input wire logic txStart,
  input wire logic txDataValid,
  input wire logic [7:0] txData,
  input wire logic txDataLast,
  input wire logic txReady,
  input wire logic txOutValid,
  input wire rfg_pkg::rfg_tx_byte_t txOut
);
  logic [7:0] guardReg;
  logic [7:0] ctrl;
  logic [7:0] guardLoad;
  logic [8:0] tickCnt;
  logic inTx;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the settings the checks depend on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      guardReg <= rfg_pkg::RST_GUARD;
      ctrl <= rfg_pkg::RST_CTRL;
    end else if (regWrite && regAddr == rfg_pkg::ADDR_GUARD) begin
      guardReg <= regWdata;
    end else if (regWrite && regAddr == rfg_pkg::ADDR_CTRL) begin
      ctrl <= regWdata;
    end
  end
  // Ticks seen while the guard runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt <= 9'h000;
      guardLoad <= 8'h00;
    end else if (txEnd) begin
      tickCnt <= 9'h000;
      guardLoad <= guardReg;
    end else if (rxGuardActive && bitClkTick) begin
      tickCnt <= tickCnt + 9'h001;
    end
  end
  // Stream mode, as opposed to the compute command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inTx <= 1'b0;
    end else if (txStart) begin
      inTx <= 1'b1;
    end else if (regWrite && regAddr == rfg_pkg::ADDR_COMMAND) begin
      inTx <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence sTake;
    txDataValid && txReady && inTx;
  endsequence
  sequence sLongTail;
    txOutValid && !txOut.last ##1 txOutValid && !txOut.last ##1 txOutValid && txOut.last;
  endsequence
  guard_load_a: assert property (txEnd && guardReg != 8'h00 |=> rxGuardActive)
    else $error("guard not started after transmit end");
  guard_zero_a: assert property (txEnd && guardReg == 8'h00 |=> !rxGuardActive [*2])
    else $error("guard ran with zero delay");
  guard_count_a: assert property (rxGuardActive |-> tickCnt < {1'b0, guardLoad})
    else $error("guard outlasted its tick count");
  guard_end_a: assert property ($fell(rxGuardActive) |-> tickCnt == {1'b0, guardLoad})
    else $error("guard ended early");
  rx_quiet_a: assert property (rxGuardActive [*3] |-> !rxOutValid && !rxFrameDone)
    else $error("receive activity decoded during guard");
  byte_pass_a: assert property (sTake |=> txOutValid && txOut.data == $past(txData)
    && txOut.parity_bit_en == ctrl[0]) else $error("transmit byte or parity enable wrong");
  parity_value_a: assert property (txOutValid && txOut.parity_bit_en |->
    txOut.parity == (^txOut.data ^ ctrl[1])) else $error("transmit parity wrong");
  long_tail_a: assert property (sTake and (txDataLast && ctrl[2] && !ctrl[4])
    |=> sLongTail) else $error("two CRC bytes not appended");
  short_tail_a: assert property (sTake and (txDataLast && ctrl[2] && ctrl[4]) |=>
    txOutValid && !txOut.last ##1 txOutValid && txOut.last ##1 !txOutValid)
    else $error("one CRC byte not appended");
  no_tail_a: assert property (sTake and (txDataLast && !ctrl[2]) |=>
    txOutValid && txOut.last ##1 !txOutValid) else $error("CRC sent while disabled");
endmodule // rfg_chk

bind rf_frame_integrity_guard rfg_chk u_chk (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .bitClkTick(bitClkTick), .txEnd(txEnd), .rxGuardActive(rxGuardActive),
  .rxOutValid(rxOutValid), .rxFrameDone(rxFrameDone), .txStart(txStart),
  .txDataValid(txDataValid), .txData(txData), .txDataLast(txDataLast), .txReady(txReady),
  .txOutValid(txOutValid), .txOut(txOut)
);
